// [src/agc_level_pkg.sv]
// package: register map, field layout, reset values and level tables for the gain control
package agc_level_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] AGC_LEVEL_CONFIG_ADDR     = 8'hb3;
   localparam logic [7:0] LEVEL_CHANNEL_CONFIG_ADDR = 8'hb5;
   localparam logic [7:0] GAIN_CONFIG_ADDR          = 8'haa; // holds light_gain_code
   localparam logic [7:0] INTEGRATION_STEP_ADDR     = 8'h81;
   localparam logic [7:0] LOW_THRESHOLD_LO_ADDR     = 8'h84;
   localparam logic [7:0] LOW_THRESHOLD_HI_ADDR     = 8'h85;
   localparam logic [7:0] HIGH_THRESHOLD_LO_ADDR    = 8'h86;
   localparam logic [7:0] HIGH_THRESHOLD_HI_ADDR    = 8'h87;
   localparam logic [7:0] PERSISTENCE_ADDR          = 8'h8c;
   localparam logic [7:0] AGC_CONTROL_ADDR          = 8'h8d;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int          DROP_LEVEL_MSB    = 7;
   localparam int          DROP_LEVEL_LSB    = 6;
   localparam int          RAISE_LEVEL_MSB   = 5;
   localparam int          RAISE_LEVEL_LSB   = 4;
   localparam int          SOURCE_MSB        = 2;
   localparam int          SOURCE_LSB        = 0;
   localparam logic [1:0]  DROP_LEVEL_RESET  = 2'h3;
   localparam logic [1:0]  RAISE_LEVEL_RESET = 2'h3;
   localparam logic [2:0]  LEVEL_CFG_LOW_RESET = 3'h2; // reserved bits 2:0 read 2
   localparam logic [2:0]  SOURCE_RESET      = 3'h0;
   localparam logic [4:0]  GAIN_CODE_RESET   = 5'h09;
   localparam logic [4:0]  GAIN_CODE_MAX     = 5'h0b;
   localparam logic [7:0]  STEP_COUNT_RESET  = 8'h00;
   localparam logic [3:0]  PERSIST_RESET     = 4'h0;
   localparam int          PERSIST_BITS      = 4;

   // channel codes
   localparam logic [2:0]  SRC_CLEAR    = 3'h0;
   localparam logic [2:0]  SRC_RED      = 3'h1;
   localparam logic [2:0]  SRC_GREEN    = 3'h2;
   localparam logic [2:0]  SRC_BLUE     = 3'h3;
   localparam logic [2:0]  SRC_WIDEBAND = 3'h4;
   localparam int          CHANNELS     = 5;

   // levels in eighths of full scale
   localparam logic [3:0]  DROP_EIGHTHS_BASE  = 4'h4; // code 0 = 4/8
   localparam logic [3:0]  RAISE_EIGHTHS_BASE = 4'h1; // code 0 = 1/8

   // counts per integration step; full scale = (steps+1)*this
   localparam logic [17:0] COUNTS_PER_STEP = 18'h0_0400;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] drop_code;
      logic [1:0] raise_code;
      logic [7:0] step_count;
      logic [4:0] gain_code;
   } level_cfg_t;

   typedef struct packed {
      logic [15:0] low;
      logic [15:0] high;
   } threshold_t;

endpackage

// [src/gain_level_decide.sv]
// gain step decision: derives both levels and requests at most one gain code step per integration
module gain_level_decide
   import agc_level_pkg::*;
(
   input  wire logic        clock_in,        // system clock
   input  wire logic        rst_n_in,        // async reset, active low
   input  wire logic        enable_in,       // clock enable
   input  wire logic        agc_on_in,       // gain control enabled
   input  wire logic        done_in,         // integration complete pulse
   input  wire level_cfg_t  cfg_in,          // level codes, steps, current gain
   input  wire logic [15:0] result_in,       // selected channel result
   output logic             step_down_out,   // gain lower request, pulse
   output logic             step_up_out      // gain raise request, pulse
);

   // -----------------------------------------------------------------
   // level arithmetic
   // -----------------------------------------------------------------
   logic [18:0] full_scale;
   logic [21:0] drop_level;
   logic [21:0] raise_level;
   logic        next_step_down;
   logic        next_step_up;

   // full scale tracks the step count; levels are eighths of it
   // 256 steps reach 2^18 counts, so full scale needs one bit more than the step constant
   always_comb begin
      full_scale  = 19'({11'h000, cfg_in.step_count} + 19'h0_0001)
                    * 19'(COUNTS_PER_STEP);
      drop_level  = 22'(({18'h0, DROP_EIGHTHS_BASE} + 22'(cfg_in.drop_code))
                        * 22'(full_scale)) >> 3;
      raise_level = 22'(({18'h0, RAISE_EIGHTHS_BASE} + 22'(cfg_in.raise_code))
                        * 22'(full_scale)) >> 3;
      next_step_down = 1'b0;
      next_step_up   = 1'b0;
      // evaluated only at end of integration; the request registers next cycle and the gain code changes one cycle later
      if (agc_on_in && done_in) begin
         if (22'(result_in) > drop_level && cfg_in.gain_code != 5'h00) begin
            next_step_down = 1'b1;
         end else if (22'(result_in) < raise_level && cfg_in.gain_code < GAIN_CODE_MAX) begin
            next_step_up = 1'b1;
         end
      end
   end

   // register the one-cycle requests
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_down_out <= 1'b0;
         step_up_out   <= 1'b0;
      end else if (enable_in) begin
         step_down_out <= next_step_down;
         step_up_out   <= next_step_up;
      end
   end

endmodule

// [src/als_agc_level_config.sv]
// top: register file, channel select, threshold persistence and gain code for light sensing
module als_agc_level_config
   import agc_level_pkg::*;
#(
   parameter int PERSIST_W = PERSIST_BITS    // width of persistence counter
)(
   input  wire logic        clock_in,         // 100 MHz system clock
   input  wire logic        rst_n_in,         // async reset, active low
   input  wire logic        enable_in,        // clock enable, freezes all state
   input  wire logic        wr_in,            // register write strobe
   input  wire logic        rd_in,            // register read strobe
   input  wire logic [7:0]  addr_in,          // register address
   input  wire logic [7:0]  wdata_in,         // write data
   output logic      [7:0]  rdata_out,        // read data, registered
   input  wire logic        sample_done_in,   // integration complete pulse
   input  wire logic [79:0] channel_data_in,  // clear,red,green,blue,wideband results
   output logic      [15:0] selected_channel_result_out, // chosen result, registered
   output logic      [4:0]  light_gain_code_out,         // current gain code
   output logic             threshold_irq_out            // threshold interrupt level
);

   // elaboration check: the persistence count is written from one register byte
   if (PERSIST_W < 1 || PERSIST_W > 8) begin : g_bad_persist_w
      $error("PERSIST_W out of range");
   end

   // -----------------------------------------------------------------
   // configuration state
   // -----------------------------------------------------------------
   logic [1:0]           gain_drop_level, next_gain_drop_level;
   logic [1:0]           gain_raise_level, next_gain_raise_level;
   logic [2:0]           level_source_select, next_level_source_select;
   logic [7:0]           integration_step_count, next_integration_step_count;
   logic [4:0]           light_gain_code, next_light_gain_code;
   threshold_t           thresholds, next_thresholds;
   logic [PERSIST_W-1:0] light_persistence_count, next_light_persistence_count;
   logic                 agc_on, next_agc_on;
   logic                 irq_on, next_irq_on;
   logic [7:0]           next_rdata;
   logic                 step_down, step_up;
   logic [15:0]          chan [CHANNELS];
   logic [15:0]          selected_channel_result, next_selected;

   // split the packed channel bus
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         assign chan[g] = channel_data_in[16*g +: 16];
      end
   endgenerate

   // channel mux; codes 5..7 fall back to clear
   always_comb begin
      next_selected = (level_source_select <= SRC_WIDEBAND) ?
                      chan[level_source_select] : chan[SRC_CLEAR];
   end

   // register writes and gain stepping
   always_comb begin
      next_gain_drop_level         = gain_drop_level;
      next_gain_raise_level        = gain_raise_level;
      next_level_source_select     = level_source_select;
      next_integration_step_count  = integration_step_count;
      next_light_gain_code         = light_gain_code;
      next_thresholds              = thresholds;
      next_light_persistence_count = light_persistence_count;
      next_agc_on                  = agc_on;
      next_irq_on                  = irq_on;
      if (wr_in) begin
         case (addr_in)
            AGC_LEVEL_CONFIG_ADDR: begin
               next_gain_drop_level  = wdata_in[DROP_LEVEL_MSB:DROP_LEVEL_LSB];
               next_gain_raise_level = wdata_in[RAISE_LEVEL_MSB:RAISE_LEVEL_LSB];
            end
            LEVEL_CHANNEL_CONFIG_ADDR: next_level_source_select = wdata_in[SOURCE_MSB:SOURCE_LSB];
            INTEGRATION_STEP_ADDR:     next_integration_step_count = wdata_in;
            GAIN_CONFIG_ADDR: begin
               // out-of-table codes are ignored
               if (wdata_in[4:0] <= GAIN_CODE_MAX) begin
                  next_light_gain_code = wdata_in[4:0];
               end
            end
            LOW_THRESHOLD_LO_ADDR:  next_thresholds.low[7:0]   = wdata_in;
            LOW_THRESHOLD_HI_ADDR:  next_thresholds.low[15:8]  = wdata_in;
            HIGH_THRESHOLD_LO_ADDR: next_thresholds.high[7:0]  = wdata_in;
            HIGH_THRESHOLD_HI_ADDR: next_thresholds.high[15:8] = wdata_in;
            PERSISTENCE_ADDR:       next_light_persistence_count = wdata_in[PERSIST_W-1:0];
            AGC_CONTROL_ADDR: begin
               next_agc_on = wdata_in[0];
               next_irq_on = wdata_in[1];
            end
            default: ;
         endcase
      end
      // hardware stepping wins over a same-cycle software gain write
      if (step_down) begin
         next_light_gain_code = light_gain_code - 5'h01;
      end else if (step_up) begin
         next_light_gain_code = light_gain_code + 5'h01;
      end
   end

   // read mux; reserved bits read as their reset values
   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            AGC_LEVEL_CONFIG_ADDR:     next_rdata = {gain_drop_level, gain_raise_level,
                                                     1'b0, LEVEL_CFG_LOW_RESET};
            LEVEL_CHANNEL_CONFIG_ADDR: next_rdata = {5'h00, level_source_select};
            INTEGRATION_STEP_ADDR:     next_rdata = integration_step_count;
            GAIN_CONFIG_ADDR:          next_rdata = {3'h0, light_gain_code};
            LOW_THRESHOLD_LO_ADDR:     next_rdata = thresholds.low[7:0];
            LOW_THRESHOLD_HI_ADDR:     next_rdata = thresholds.low[15:8];
            HIGH_THRESHOLD_LO_ADDR:    next_rdata = thresholds.high[7:0];
            HIGH_THRESHOLD_HI_ADDR:    next_rdata = thresholds.high[15:8];
            PERSISTENCE_ADDR:          next_rdata = 8'(light_persistence_count);
            AGC_CONTROL_ADDR:          next_rdata = {6'h00, irq_on, agc_on};
            default:                   next_rdata = 8'h00;
         endcase
      end
   end

   // register stage for configuration
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gain_drop_level         <= DROP_LEVEL_RESET;
         gain_raise_level        <= RAISE_LEVEL_RESET;
         level_source_select     <= SOURCE_RESET;
         integration_step_count  <= STEP_COUNT_RESET;
         light_gain_code         <= GAIN_CODE_RESET;
         thresholds              <= '0;
         light_persistence_count <= PERSIST_W'(PERSIST_RESET);
         agc_on                  <= 1'b0;
         irq_on                  <= 1'b0;
         rdata_out               <= 8'h00;
         selected_channel_result <= 16'h0000;
      end else if (enable_in) begin
         gain_drop_level         <= next_gain_drop_level;
         gain_raise_level        <= next_gain_raise_level;
         level_source_select     <= next_level_source_select;
         integration_step_count  <= next_integration_step_count;
         light_gain_code         <= next_light_gain_code;
         thresholds              <= next_thresholds;
         light_persistence_count <= next_light_persistence_count;
         agc_on                  <= next_agc_on;
         irq_on                  <= next_irq_on;
         rdata_out               <= next_rdata;
         selected_channel_result <= next_selected;
      end
   end

   assign selected_channel_result_out = selected_channel_result;
   assign light_gain_code_out         = light_gain_code;

   // -----------------------------------------------------------------
   // gain decision
   // -----------------------------------------------------------------
   level_cfg_t dcfg;
   assign dcfg = '{drop_code: gain_drop_level, raise_code: gain_raise_level,
                   step_count: integration_step_count, gain_code: light_gain_code};

   gain_level_decide u_decide (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .enable_in     (enable_in),
      .agc_on_in     (agc_on),
      .done_in       (sample_done_in),
      .cfg_in        (dcfg),
      .result_in     (next_selected),
      .step_down_out (step_down),
      .step_up_out   (step_up)
   );

   // -----------------------------------------------------------------
   // threshold persistence
   // -----------------------------------------------------------------
   logic [PERSIST_W-1:0] miss_run, next_miss_run;
   logic                 irq, next_irq;
   logic                 outside;

   // count consecutive out-of-range samples; a value of 0 fires on every out-of-range sample
   always_comb begin
      outside      = (next_selected < thresholds.low) || (next_selected > thresholds.high);
      next_miss_run = miss_run;
      next_irq      = irq && irq_on;
      if (sample_done_in) begin
         if (!outside) begin
            next_miss_run = '0;
         end else begin
            if (miss_run != {PERSIST_W{1'b1}}) begin
               next_miss_run = miss_run + 1'b1;
            end
            if (irq_on && miss_run >= light_persistence_count) begin
               next_irq = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         miss_run <= '0;
         irq      <= 1'b0;
      end else if (enable_in) begin
         miss_run <= next_miss_run;
         irq      <= next_irq;
      end
   end

   assign threshold_irq_out = irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_gain_in_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      light_gain_code <= GAIN_CODE_MAX) else $error("gain code beyond table");
   a_drop_steps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      enable_in && step_down |=> light_gain_code == $past(light_gain_code) - 5'h01)
      else $error("gain did not step down");
   a_raise_steps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      enable_in && step_up |=> light_gain_code == $past(light_gain_code) + 5'h01)
      else $error("gain did not step up");
   a_step_on_done: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (step_down || step_up) |-> $past(sample_done_in && agc_on))
      else $error("gain step without integration end");
   a_drop_field: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      enable_in && wr_in && addr_in == AGC_LEVEL_CONFIG_ADDR
      |=> gain_drop_level == $past(wdata_in[7:6])) else $error("drop level not stored");
   a_source_field: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      enable_in && wr_in && addr_in == LEVEL_CHANNEL_CONFIG_ADDR
      |=> level_source_select == $past(wdata_in[2:0])) else $error("source not stored");
   a_source_route: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      enable_in && level_source_select == SRC_BLUE && $stable(level_source_select)
      |=> selected_channel_result == $past(chan[SRC_BLUE])) else $error("wrong channel");
   a_irq_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      $rose(irq) |-> $past(sample_done_in && outside)) else $error("irq without cause");
   a_levels_ordered: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      u_decide.raise_level <= u_decide.drop_level) else $error("levels crossed");

   c_step_down: cover property (@(posedge clock_in) step_down);
   c_step_up:   cover property (@(posedge clock_in) step_up);
   c_irq:       cover property (@(posedge clock_in) $rose(irq));
   c_wideband:  cover property (@(posedge clock_in) level_source_select == SRC_WIDEBAND);

endmodule

// [test/host_bus_model.sv]
// host side model: drives the register strobes of the block
module host_bus_model (
   input  wire logic       clock_in,  // system clock
   output logic            wr_out,    // write strobe
   output logic            rd_out,    // read strobe
   output logic      [7:0] addr_out,  // register address
   output logic      [7:0] wdata_out, // write data
   input  wire logic [7:0] rdata_in   // read data from the block
);
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // idle state
   // -----------------------------------------------------------------
   // bus starts idle, address and data deliberately nonzero
   initial begin
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = 8'hff;
      wdata_out = 8'h5a;
   end

   // -----------------------------------------------------------------
   // access tasks
   // -----------------------------------------------------------------
   // one write; released lines show the inverse so stale data never matches
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr_out    <= 1'b1;
      addr_out  <= a;
      wdata_out <= d;
      @(posedge clock_in);
      wr_out    <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask

   // one read; data is taken 1 ns after the edge that accepts the read
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      rd_out   <= 1'b1;
      addr_out <= a;
      @(posedge clock_in);
      #1 d = rdata_in;
      @(posedge clock_in);
      rd_out   <= 1'b0;
      addr_out <= ~a;
   endtask
endmodule

// [test/als_agc_level_config_tb.sv]
// testbench: register access, level decisions, channel select and interrupt
module als_agc_level_config_tb;
   import agc_level_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock_in;
   logic        rst_n;
   logic        enable;
   logic        wr;
   logic        rd;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        sample_done;
   logic [79:0] channel_data;
   logic [15:0] selected;
   logic [4:0]  gain_code;
   logic        irq;
   logic [7:0]  rv;
   int          mismatches;
   int          comparisons;

   // -----------------------------------------------------------------
   // block and host model
   // -----------------------------------------------------------------
   als_agc_level_config dut (
      .clock_in(clock_in), .rst_n_in(rst_n), .enable_in(enable), .wr_in(wr), .rd_in(rd),
      .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .sample_done_in(sample_done),
      .channel_data_in(channel_data), .selected_channel_result_out(selected),
      .light_gain_code_out(gain_code), .threshold_irq_out(irq));

   host_bus_model host (
      .clock_in(clock_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
      .wdata_out(wdata), .rdata_in(rdata));

   // clock at 100 MHz
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // read a register and compare its value
   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      host.read_reg(a, rv);
      check("register read", 16'(rv), 16'(exp));
   endtask

   // one integration with the same result on every channel, then look at outputs
   task automatic sample(input logic [15:0] res, input logic [4:0] g, input logic i);
      @(posedge clock_in);
      channel_data <= {5{res}};
      sample_done  <= 1'b1;
      @(posedge clock_in);
      sample_done <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      check("gain code", 16'(gain_code), 16'(g));
      check("threshold irq", 16'(irq), 16'(i));
   endtask

   // verdict, reached from the main sequence or the watchdog
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // the whole run needs a few hundred cycles; stop far beyond that
   initial begin
      #200_000;
      mismatches++;
      summarize();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      mismatches   = 0;
      comparisons  = 0;
      rst_n        = 1'b0;
      enable       = 1'b1;
      sample_done  = 1'b0;
      channel_data = 80'h0;
      repeat (16) @(posedge clock_in);
      rst_n <= 1'b1;
      // reset values and an unmapped place
      read_check(AGC_LEVEL_CONFIG_ADDR, 8'hf2);
      read_check(LEVEL_CHANNEL_CONFIG_ADDR, 8'h00);
      read_check(GAIN_CONFIG_ADDR, 8'h09);
      read_check(8'hb4, 8'h00);
      // every level code pair reads back with the reserved bits fixed
      for (int c = 0; c < 16; c++) begin
         host.write_reg(AGC_LEVEL_CONFIG_ADDR, {c[3:0], 4'hf});
         read_check(AGC_LEVEL_CONFIG_ADDR, {c[3:0], 4'h2});
      end
      // each channel code routes its own result
      channel_data <= {16'h5005, 16'h4004, 16'h3003, 16'h2002, 16'h1001};
      // codes 5..7 fall back to the clear channel
      for (int c = 0; c < 8; c++) begin
         host.write_reg(LEVEL_CHANNEL_CONFIG_ADDR, 8'(c));
         read_check(LEVEL_CHANNEL_CONFIG_ADDR, 8'(c));
         check("selected result", selected, 16'((c < 5) ? c + 1 : 1) * 16'h1001);
      end
      host.write_reg(LEVEL_CHANNEL_CONFIG_ADDR, 8'h00);
      host.write_reg(AGC_CONTROL_ADDR, 8'h01);
      host.write_reg(INTEGRATION_STEP_ADDR, 8'h00);
      // drop level (4+d)/8 of 1024 counts, strictly above
      for (int d = 0; d < 4; d++) begin
         host.write_reg(GAIN_CONFIG_ADDR, 8'h05);
         host.write_reg(AGC_LEVEL_CONFIG_ADDR, {d[1:0], 6'h00});
         sample(16'((4 + d) * 128), 5'h05, 1'b0);
         sample(16'((4 + d) * 128 + 1), 5'h04, 1'b0);
      end
      // raise level (1+r)/8 of 1024 counts, strictly below
      for (int r = 0; r < 4; r++) begin
         host.write_reg(GAIN_CONFIG_ADDR, 8'h05);
         host.write_reg(AGC_LEVEL_CONFIG_ADDR, {2'h3, r[1:0], 4'h0});
         sample(16'((1 + r) * 128), 5'h05, 1'b0);
         sample(16'((1 + r) * 128 - 1), 5'h06, 1'b0);
      end
      // two steps double full scale: 1792 and 1024 become the levels
      host.write_reg(INTEGRATION_STEP_ADDR, 8'h01);
      sample(16'h0700, 5'h06, 1'b0);
      sample(16'h0701, 5'h05, 1'b0);
      sample(16'h0400, 5'h05, 1'b0);
      sample(16'h03ff, 5'h06, 1'b0);
      // 256 steps: full scale above any 16-bit result, so only raising is possible
      host.write_reg(INTEGRATION_STEP_ADDR, 8'hff);
      sample(16'hffff, 5'h07, 1'b0);
      host.write_reg(INTEGRATION_STEP_ADDR, 8'h01);
      // gain code ends hold, an out-of-range code is ignored
      host.write_reg(GAIN_CONFIG_ADDR, 8'h00);
      sample(16'hffff, 5'h00, 1'b0);
      host.write_reg(GAIN_CONFIG_ADDR, 8'h0b);
      sample(16'h0000, 5'h0b, 1'b0);
      host.write_reg(GAIN_CONFIG_ADDR, 8'h0c);
      read_check(GAIN_CONFIG_ADDR, 8'h0b);
      // clock enable low: a write must not land
      enable <= 1'b0;
      host.write_reg(GAIN_CONFIG_ADDR, 8'h03);
      enable <= 1'b1;
      read_check(GAIN_CONFIG_ADDR, 8'h0b);
      // control off: no step at all
      host.write_reg(AGC_CONTROL_ADDR, 8'h00);
      sample(16'hffff, 5'h0b, 1'b0);
      // window 0x0100..0x0800, three outside samples in a row needed
      host.write_reg(LOW_THRESHOLD_LO_ADDR, 8'h00);
      host.write_reg(LOW_THRESHOLD_HI_ADDR, 8'h01);
      host.write_reg(HIGH_THRESHOLD_LO_ADDR, 8'h00);
      host.write_reg(HIGH_THRESHOLD_HI_ADDR, 8'h08);
      host.write_reg(PERSISTENCE_ADDR, 8'h02);
      host.write_reg(AGC_CONTROL_ADDR, 8'h02);
      // an inside sample clears the outside run left by earlier tests
      sample(16'h0500, 5'h0b, 1'b0);
      sample(16'h0900, 5'h0b, 1'b0);
      sample(16'h0900, 5'h0b, 1'b0);
      sample(16'h0800, 5'h0b, 1'b0);
      sample(16'h00ff, 5'h0b, 1'b0);
      sample(16'h0100, 5'h0b, 1'b0);
      sample(16'h0801, 5'h0b, 1'b0);
      sample(16'h00ff, 5'h0b, 1'b0);
      sample(16'h0801, 5'h0b, 1'b1);
      sample(16'h0500, 5'h0b, 1'b1);
      host.write_reg(AGC_CONTROL_ADDR, 8'h00);
      @(posedge clock_in);
      #1;
      check("threshold irq", 16'(irq), 16'h0000);
      summarize();
   end
endmodule
